/* hw/ocm_params.svh */
// Constants for the output cell: reset values and defaults of the configuration options
`ifndef OCM_PARAMS_SVH
`define OCM_PARAMS_SVH

// Value that stands for "true" in every configuration expression
`define OCM_EXPR_TRUE 1'b1
// Value that stands for "false" in every configuration expression
`define OCM_EXPR_FALSE 1'b0

// Default of both simultaneous set-and-clear output values
`define OCM_BOTH_DEFAULT 1'b1

// Set and clear enables when not assigned, per cell type
`define OCM_ENABLE_DEFAULT_REG 1'b1
`define OCM_ENABLE_DEFAULT_OTHER 1'b0

// Fixed output pair for an unreachable cell type code; the clock-sample value goes unused, the sample follows the clock in reset
`define OCM_CLK_PREV_RESET 1'b0
`define OCM_TRUE_RESET 1'b0
`define OCM_COMP_RESET 1'b1

`endif

/* hw/ocm_pkg.sv */
// Types shared by the output cell: cell type and the registered state
package ocm_pkg;

    typedef enum logic [1:0] {
        OCM_TYPE_COMB,
        OCM_TYPE_LATCH,
        OCM_TYPE_REG
    } ocm_type_t;

    typedef struct packed {
        ocm_type_t cell_type;
        logic clk_prev;
        logic held_true;
        logic held_comp;
        logic true_out;
        logic comp_out;
    } ocm_state_t;

endpackage : ocm_pkg

/* hw/ocm_output_cell.sv */
// Configurable output cell: register, transparent latch or combinatorial stage
`timescale 1ns/10ps
`include "ocm_params.svh"

module ocm_output_cell
    import ocm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    // Live inputs from the product-term array, same clock domain
    input wire logic data_in,
    input wire logic cell_clk,
    input wire logic set_in,
    input wire logic clear_in,
    input wire logic preload_enable,
    input wire logic preload_value_in,
    // Static configuration
    input wire logic reg_select,
    input wire logic latch_select,
    input wire logic enable_set_given,
    input wire logic enable_set_input,
    input wire logic enable_clear_given,
    input wire logic enable_clear_input,
    input wire logic async_set_select,
    input wire logic async_clear_select,
    input wire logic both_values_given,
    input wire logic true_out_on_both,
    input wire logic comp_out_on_both,
    input wire logic initial_true_out,
    input wire logic initial_comp_given,
    input wire logic initial_comp_out,
    input wire logic flip_clock_polarity,
    input wire logic flip_preload_enable,
    input wire logic flip_preload_value,
    input wire logic flip_true_out,
    input wire logic flip_comp_out,
    // Outputs
    output logic true_out,
    output logic comp_out,
    output ocm_type_t cell_type_out
);

    ocm_state_t state_reg;
    ocm_state_t state_next;

    // Decoded configuration
    logic reg_chosen;
    logic latch_chosen;
    ocm_type_t type_sel;
    logic set_enabled;
    logic clear_enabled;
    logic both_true_val;
    logic both_comp_val;
    logic init_true_val;
    logic init_comp_val;

    // Conditioned live inputs
    logic clk_eff;
    logic pl_eff;
    logic pd_eff;
    logic clk_rise;

    // Set and clear requests, gated by preload and their enables
    logic set_req;
    logic clear_req;

    // Register cell candidates
    logic reg_set_act;
    logic reg_clear_act;
    logic reg_true;
    logic reg_comp;

    // Latch cell candidates
    logic latch_set_act;
    logic latch_clear_act;
    logic latch_true;
    logic latch_comp;

    // Combinatorial cell candidates
    logic comb_set_act;
    logic comb_clear_act;
    logic comb_true;
    logic comb_comp;

    // Values that the held pair takes this cycle
    logic new_true;
    logic new_comp;

    // Pair loaded while reset is applied
    logic start_true;
    logic start_comp;

    // Held pair after the output inversions
    logic out_true;
    logic out_comp;

    // All live inputs are sampled by sys_clk, so this is a synchronous model of
    // the output stage. An asynchronous set or clear, an opening latch or a data
    // change reaches the pins one sys_clk edge later, not at once, and a pulse
    // on a live input shorter than one sys_clk period may go unseen. A slow
    // cell clock is therefore expected. Traded for one clock domain and no
    // combinational path from the term inputs to the pins.

    // Selector levels; register wins over latch when both are true
    always_comb begin
        reg_chosen = (reg_select == `OCM_EXPR_TRUE);
        latch_chosen = (latch_select == `OCM_EXPR_TRUE) && !reg_chosen;
    end

    // Cell type from the static selectors
    always_comb begin
        if (reg_chosen) begin
            type_sel = OCM_TYPE_REG;
        end else if (latch_chosen) begin
            type_sel = OCM_TYPE_LATCH;
        end else begin
            type_sel = OCM_TYPE_COMB;
        end
    end

    // Enable defaults depend on the cell type when not assigned
    always_comb begin
        if (enable_set_given) begin
            set_enabled = enable_set_input;
        end else if (type_sel == OCM_TYPE_REG) begin
            set_enabled = `OCM_ENABLE_DEFAULT_REG;
        end else begin
            set_enabled = `OCM_ENABLE_DEFAULT_OTHER;
        end
        if (enable_clear_given) begin
            clear_enabled = enable_clear_input;
        end else if (type_sel == OCM_TYPE_REG) begin
            clear_enabled = `OCM_ENABLE_DEFAULT_REG;
        end else begin
            clear_enabled = `OCM_ENABLE_DEFAULT_OTHER;
        end
    end

    // Both-active values; unassigned ones default to true
    always_comb begin
        if (both_values_given) begin
            both_true_val = true_out_on_both;
            both_comp_val = comp_out_on_both;
        end else begin
            both_true_val = `OCM_BOTH_DEFAULT;
            both_comp_val = `OCM_BOTH_DEFAULT;
        end
    end

    // Initial pair; unassigned complement defaults to the inverse of true
    always_comb begin
        init_true_val = initial_true_out;
        if (initial_comp_given) begin
            init_comp_val = initial_comp_out;
        end else begin
            init_comp_val = ~initial_true_out;
        end
    end

    // Input inversions applied before any use
    always_comb begin
        clk_eff = cell_clk ^ flip_clock_polarity;
        pl_eff = preload_enable ^ flip_preload_enable;
        pd_eff = preload_value_in ^ flip_preload_value;
    end

    // Edge seen against last cycle's sample of the effective clock
    always_comb begin
        clk_rise = clk_eff & ~state_reg.clk_prev;
    end

    // Preload blocks set and clear before any cell type sees them
    always_comb begin
        set_req = ~pl_eff & set_enabled & set_in;
        clear_req = ~pl_eff & clear_enabled & clear_in;
    end

    // Register cell: synchronous set and clear need a seen rising edge
    always_comb begin
        reg_set_act = set_req & (async_set_select | clk_rise);
        reg_clear_act = clear_req & (async_clear_select | clk_rise);
        reg_true = state_reg.held_true;
        reg_comp = state_reg.held_comp;
        if (reg_set_act && reg_clear_act) begin
            reg_true = both_true_val;
            reg_comp = both_comp_val;
        end else if (reg_clear_act) begin
            reg_true = 1'b0;
            reg_comp = 1'b1;
        end else if (reg_set_act) begin
            reg_true = 1'b1;
            reg_comp = 1'b0;
        end else if (clk_rise) begin
            reg_true = data_in;
            reg_comp = ~data_in;
        end
    end

    // Latch cell: synchronous set and clear act while the clock is active
    always_comb begin
        latch_set_act = set_req & (async_set_select | clk_eff);
        latch_clear_act = clear_req & (async_clear_select | clk_eff);
        latch_true = state_reg.held_true;
        latch_comp = state_reg.held_comp;
        if (latch_set_act && latch_clear_act) begin
            latch_true = both_true_val;
            latch_comp = both_comp_val;
        end else if (latch_clear_act) begin
            latch_true = 1'b0;
            latch_comp = 1'b1;
        end else if (latch_set_act) begin
            latch_true = 1'b1;
            latch_comp = 1'b0;
        end else if (clk_eff) begin
            latch_true = data_in;
            latch_comp = ~data_in;
        end
    end

    // Combinatorial cell: clock ignored; data flows unless set or clear act
    // Asynchronous selects change nothing here, both already act at once
    always_comb begin
        comb_set_act = set_req;
        comb_clear_act = clear_req;
        comb_true = data_in;
        comb_comp = ~data_in;
        if (comb_set_act && comb_clear_act) begin
            comb_true = both_true_val;
            comb_comp = both_comp_val;
        end else if (comb_clear_act) begin
            comb_true = 1'b0;
            comb_comp = 1'b1;
        end else if (comb_set_act) begin
            comb_true = 1'b1;
            comb_comp = 1'b0;
        end
    end

    // Preload first, then the pair of the selected cell type
    always_comb begin
        if (pl_eff) begin
            new_true = pd_eff;
            new_comp = ~pd_eff;
        end else begin
            case (type_sel)
                OCM_TYPE_REG: begin
                    new_true = reg_true;
                    new_comp = reg_comp;
                end
                OCM_TYPE_LATCH: begin
                    new_true = latch_true;
                    new_comp = latch_comp;
                end
                OCM_TYPE_COMB: begin
                    new_true = comb_true;
                    new_comp = comb_comp;
                end
                default: begin
                    // Unreachable type code: keep the held pair
                    new_true = state_reg.held_true;
                    new_comp = state_reg.held_comp;
                end
            endcase
        end
    end

    // Reset pair; combinatorial cells ignore the initial settings
    always_comb begin
        case (type_sel)
            OCM_TYPE_REG, OCM_TYPE_LATCH: begin
                start_true = init_true_val;
                start_comp = init_comp_val;
            end
            OCM_TYPE_COMB: begin
                start_true = data_in;
                start_comp = ~data_in;
            end
            default: begin
                // Unreachable type code: fixed pair
                start_true = `OCM_TRUE_RESET;
                start_comp = `OCM_COMP_RESET;
            end
        endcase
    end

    // Output inversions apply after the both-active values as well
    always_comb begin
        if (srst) begin
            out_true = start_true ^ flip_true_out;
            out_comp = start_comp ^ flip_comp_out;
        end else begin
            out_true = new_true ^ flip_true_out;
            out_comp = new_comp ^ flip_comp_out;
        end
    end

    // Configuration is decoded, never stored, so it must stay static
    always_comb begin
        state_next = state_reg;
        state_next.cell_type = type_sel;
        state_next.clk_prev = clk_eff; // Also in reset: no false edge at release
        state_next.true_out = out_true;
        state_next.comp_out = out_comp;
        if (srst) begin
            state_next.held_true = start_true;
            state_next.held_comp = start_comp;
        end else begin
            state_next.held_true = new_true;
            state_next.held_comp = new_comp;
        end
    end

    // One register stage holds all state; every output comes straight from it
    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    assign true_out = state_reg.true_out;
    assign comp_out = state_reg.comp_out;
    assign cell_type_out = state_reg.cell_type;

endmodule : ocm_output_cell

/* verification/ocm_output_cell_chk.sv */
// Port-level assertions for the output cell
`timescale 1ns/10ps
module ocm_output_cell_chk
    import ocm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic data_in,
    input wire logic cell_clk,
    input wire logic set_in,
    input wire logic clear_in,
    input wire logic preload_enable,
    input wire logic preload_value_in,
    input wire logic reg_select,
    input wire logic latch_select,
    input wire logic flip_clock_polarity,
    input wire logic flip_preload_enable,
    input wire logic flip_preload_value,
    input wire logic flip_true_out,
    input wire logic flip_comp_out,
    input wire logic true_out,
    input wire logic comp_out,
    input wire ocm_type_t cell_type_out
);
    logic ck, pl_on, quiet, rise, prev_ck_reg;
    assign ck = cell_clk ^ flip_clock_polarity;
    assign pl_on = preload_enable ^ flip_preload_enable;
    assign quiet = !pl_on && !set_in && !clear_in;
    assign rise = ck && !prev_ck_reg;
    always_ff @(posedge sys_clk) begin
        prev_ck_reg <= ck;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_type_reg: assert property (reg_select |=> cell_type_out == OCM_TYPE_REG)
        else $error("register type not taken");
    a_type_latch: assert property (!reg_select && latch_select |=> cell_type_out == OCM_TYPE_LATCH)
        else $error("latch type not taken");
    a_preload_true: assert property (pl_on |=> true_out == ($past(preload_value_in) ^ flip_preload_value ^ flip_true_out))
        else $error("true output ignores preload");
    a_preload_comp: assert property (pl_on |=> comp_out == (!$past(preload_value_in) ^ flip_preload_value ^ flip_comp_out))
        else $error("complement ignores preload");
    a_comb_follows: assert property (!reg_select && !latch_select && quiet |=> true_out == ($past(data_in) ^ flip_true_out))
        else $error("comb cell not following data");
    a_latch_pass: assert property (!reg_select && latch_select && quiet && ck |=> true_out == ($past(data_in) ^ flip_true_out))
        else $error("open latch not passing data");
    a_reg_capture: assert property (reg_select && quiet && rise |=> true_out == ($past(data_in) ^ flip_true_out))
        else $error("register missed rising edge");
    a_reg_holds: assert property (reg_select && quiet && !rise |=> $stable(true_out) && $stable(comp_out))
        else $error("register changed without edge");
    c_preload_end: cover property (pl_on ##1 !pl_on);
    c_both_active: cover property (!pl_on && set_in && clear_in);
    c_latch_open: cover property (cell_type_out == OCM_TYPE_LATCH && ck);
endmodule : ocm_output_cell_chk

bind ocm_output_cell ocm_output_cell_chk u_chk (
    .sys_clk(sys_clk),
    .srst(srst),
    .data_in(data_in),
    .cell_clk(cell_clk),
    .set_in(set_in),
    .clear_in(clear_in),
    .preload_enable(preload_enable),
    .preload_value_in(preload_value_in),
    .reg_select(reg_select),
    .latch_select(latch_select),
    .flip_clock_polarity(flip_clock_polarity),
    .flip_preload_enable(flip_preload_enable),
    .flip_preload_value(flip_preload_value),
    .flip_true_out(flip_true_out),
    .flip_comp_out(flip_comp_out),
    .true_out(true_out),
    .comp_out(comp_out),
    .cell_type_out(cell_type_out)
);

/* verification/ocm_term_array.sv */
// Random product-term drive for the cell's live inputs
`timescale 1ns/10ps
module ocm_term_array (
    input wire logic sys_clk,
    output logic data_in,
    output logic cell_clk,
    output logic set_in,
    output logic clear_in,
    output logic preload_enable,
    output logic preload_value_in
);
    initial {data_in, cell_clk, set_in, clear_in, preload_enable, preload_value_in} = 6'h00;
    // Preload kept rare so clocking and set/clear get exercised
    always @(posedge sys_clk) begin
        {data_in, cell_clk, preload_value_in} <= 3'($urandom);
        set_in <= ($urandom % 4) == 0;
        clear_in <= ($urandom % 4) == 0;
        preload_enable <= ($urandom % 8) == 0;
    end
endmodule : ocm_term_array

/* verification/ocm_output_cell_test.sv */
// Self-checking bench for the output cell with a reference model
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t mismatch %b vs %b", $time, a, b); end end
module ocm_output_cell_test
    import ocm_pkg::*;
;
    logic sys_clk = 1'b0, srst = 1'b1, started = 1'b0;
    logic [18:0] cfg = 19'h00000;
    logic data_in, cell_clk, set_in, clear_in, preload_enable, preload_value_in;
    logic true_out, comp_out, m_q, m_qb, m_clk, ck, pl, isr, isl, qual, s, c, e_q, e_qb;
    ocm_type_t cell_type_out, m_type;
    int n_errors = 0;
    int samples_checked = 0;
    function automatic ocm_type_t exp_type(input logic [18:0] f);
        return f[0] ? OCM_TYPE_REG : (f[1] ? OCM_TYPE_LATCH : OCM_TYPE_COMB);
    endfunction : exp_type
    // Both-active pair; unassigned values default to true
    function automatic logic [1:0] exp_both(input logic [18:0] f);
        return f[8] ? {f[9], f[10]} : 2'h3;
    endfunction : exp_both
    initial forever #20 sys_clk = !sys_clk;
    ocm_term_array u_terms (.sys_clk(sys_clk), .data_in(data_in), .cell_clk(cell_clk),
        .set_in(set_in), .clear_in(clear_in), .preload_enable(preload_enable),
        .preload_value_in(preload_value_in));
    ocm_output_cell dut (.sys_clk(sys_clk), .srst(srst), .data_in(data_in),
        .cell_clk(cell_clk), .set_in(set_in), .clear_in(clear_in),
        .preload_enable(preload_enable), .preload_value_in(preload_value_in),
        .reg_select(cfg[0]), .latch_select(cfg[1]), .enable_set_given(cfg[2]),
        .enable_set_input(cfg[3]), .enable_clear_given(cfg[4]), .enable_clear_input(cfg[5]),
        .async_set_select(cfg[6]), .async_clear_select(cfg[7]), .both_values_given(cfg[8]),
        .true_out_on_both(cfg[9]), .comp_out_on_both(cfg[10]), .initial_true_out(cfg[11]),
        .initial_comp_given(cfg[12]), .initial_comp_out(cfg[13]),
        .flip_clock_polarity(cfg[14]), .flip_preload_enable(cfg[15]),
        .flip_preload_value(cfg[16]), .flip_true_out(cfg[17]), .flip_comp_out(cfg[18]),
        .true_out(true_out), .comp_out(comp_out), .cell_type_out(cell_type_out));
    // Reference model, sees inputs as sampled at this edge
    always @(posedge sys_clk) begin
        ck = cell_clk ^ cfg[14];
        pl = preload_enable ^ cfg[15];
        isr = cfg[0];
        isl = !cfg[0] && cfg[1];
        m_type = exp_type(cfg);
        qual = isr ? (ck && !m_clk) : (isl ? ck : 1'b1);
        s = set_in && (cfg[2] ? cfg[3] : isr) && (cfg[6] || qual);
        c = clear_in && (cfg[4] ? cfg[5] : isr) && (cfg[7] || qual);
        if (srst && (isr || isl))
            {m_q, m_qb} = {cfg[11], cfg[12] ? cfg[13] : !cfg[11]};
        else if (srst)
            {m_q, m_qb} = {data_in, !data_in};
        else if (pl)
            {m_q, m_qb} = {preload_value_in ^ cfg[16], !(preload_value_in ^ cfg[16])};
        else if (s && c)
            {m_q, m_qb} = exp_both(cfg);
        else if (c)
            {m_q, m_qb} = 2'h1;
        else if (s)
            {m_q, m_qb} = 2'h2;
        else if (qual)
            {m_q, m_qb} = {data_in, !data_in};
        m_clk = ck;
        // Output flips taken with the edge, as cfg may change right after it
        e_q = m_q ^ cfg[17];
        e_qb = m_qb ^ cfg[18];
        started = 1'b1;
    end
    always @(negedge sys_clk) begin
        if (started) begin
            `CHK(true_out, e_q)
            `CHK(comp_out, e_qb)
            `CHK(cell_type_out, m_type)
        end
    end
    task automatic conclude();
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    initial begin
        #600000;
        n_errors++;
        conclude();
    end
    // First three setups: plain comb, both selectors true, latch with async enables
    initial begin
        void'($urandom(32776));
        for (int k = 0; k < 40; k++) begin
            srst <= 1'b1;
            cfg <= (k == 0) ? 19'h00000 : (k == 1) ? 19'h00003 : (k == 2) ? 19'h000fe
                : 19'($urandom);
            repeat (6) @(posedge sys_clk);
            srst <= 1'b0;
            repeat (300) @(posedge sys_clk);
        end
        conclude();
    end
endmodule : ocm_output_cell_test
